// ==== design/gcrm_map.vh ====
`ifndef GCRM_MAP_VH
`define GCRM_MAP_VH
`define GCRM_CODE_CONTROL_COMMAND_WORD 8'h00
`define GCRM_CODE_CONTROL_HI 8'h01
`define GCRM_CODE_AT_RATE_CURRENT 8'h02
`define GCRM_CODE_AT_RATE_HI 8'h03
`define GCRM_CODE_AT_RATE_TIME_TO_EMPTY 8'h04
`define GCRM_CODE_THERMAL_READING 8'h06
`define GCRM_CODE_CELL_POTENTIAL_MV 8'h08
`define GCRM_CODE_GAUGE_INDICATOR_BITS 8'h0A
`define GCRM_CODE_NOMINAL_AVAILABLE_CAPACITY 8'h0C
`define GCRM_CODE_FULL_AVAILABLE_CAPACITY 8'h0E
`define GCRM_CODE_REMAINING_CAPACITY 8'h10
`define GCRM_CODE_FULL_CHARGE_CAPACITY 8'h12
`define GCRM_CODE_AVERAGE_CURRENT 8'h14
`define GCRM_CODE_TIME_TO_EMPTY 8'h16
`define GCRM_CODE_TIME_TO_FULL 8'h18
`define GCRM_CODE_STANDBY_CURRENT 8'h1A
`define GCRM_CODE_STANDBY_TIME_TO_EMPTY 8'h1C
`define GCRM_CODE_MAX_LOAD_CURRENT 8'h1E
`define GCRM_CODE_MAX_LOAD_TIME_TO_EMPTY 8'h20
`define GCRM_CODE_AVAILABLE_ENERGY 8'h22
`define GCRM_CODE_AVERAGE_POWER 8'h24
`define GCRM_CODE_CONSTANT_POWER_TIME_TO_EMPTY 8'h26
`define GCRM_CODE_STATE_OF_HEALTH 8'h28
`define GCRM_CODE_GAP 8'h2A
`define GCRM_CODE_STATE_OF_CHARGE 8'h2C
`define GCRM_CODE_NORMALIZED_IMPEDANCE_CAL 8'h2E
`define GCRM_CODE_INSTANTANEOUS_CURRENT 8'h30
`define GCRM_CODE_REG_END 8'h32
`define GCRM_CODE_FLASH_BLOCK_SELECT 8'h3F
`define GCRM_CODE_FLASH_BASE 8'h40
`define GCRM_CODE_FLASH_END 8'h60
`define GCRM_SUB_STATUS 16'h0000
`define GCRM_SUB_SET_HIBERNATE 16'h0011
`define GCRM_SUB_CLEAR_HIBERNATE 16'h0012
`define GCRM_SUB_SET_SNOOZE 16'h0013
`define GCRM_SUB_CLEAR_SNOOZE 16'h0014
`define GCRM_SUB_LOCK 16'h0020
`define GCRM_UNLOCK_KEY0 16'h1A2B
`define GCRM_UNLOCK_KEY1 16'h3C4D
`define GCRM_STAT_LOCKED_BIT 13
`define GCRM_STAT_INITCOMP_BIT 7
`define GCRM_STAT_HIBERNATE_BIT 6
`define GCRM_STAT_SNOOZE_BIT 5
`define GCRM_STAT_SLEEP_BIT 4
`define GCRM_CLK_MHZ 10
`define GCRM_SOC_PULSE_US 1000
`define GCRM_DEV_ADDR 7'h2A
`endif

// ==== design/gcrm_mem.v ====
`timescale 1ns/10ps
module gcrm_mem #(
  parameter AW = 5,
  parameter LN = 2
) (
  input wire clk,
  input wire [AW-1:0] addr,
  input wire [LN-1:0] we,
  input wire [8*LN-1:0] wdata,
  output reg [8*LN-1:0] rdata
);
  reg [8*LN-1:0] mem [0:(1<<AW)-1];
  integer i;

  // byte lanes so a single byte of a word can be written alone
  always @(posedge clk)
  begin
    for (i = 0; i < LN; i = i + 1)
    begin
      if (we[i])
      begin
        mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
    end
    rdata <= mem[addr];
  end
endmodule

// ==== design/gcrm_sync.v ====
`timescale 1ns/10ps
module gcrm_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire rst_b,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ==== design/gcrm_top.v ====
// Functional notes
// - standard battery values are sixteen-bit words held in the map.
// - each word sits at an even command code plus the following odd.
// - host sends command code, then reads or writes data bytes.
// - standard command writes are taken in the normal power mode.
// - locked mode allows writes only to control and at-rate words.
// - commands reach control, status registers and data-flash bytes.
// - flash reached via block select and offset, writes only unlocked.
// - two user data-flash blocks of thirty-two bytes each.
// - five power modes change on events and on host requests.
// - a state-of-charge interrupt pulse is driven toward the host.
`timescale 1ns/10ps
`include "gcrm_map.vh"
module gcrm_top #(
  parameter [6:0] DEV_ADDR = `GCRM_DEV_ADDR,
  parameter SOC_PULSE_CYC = `GCRM_SOC_PULSE_US * `GCRM_CLK_MHZ
) (
  input wire CORE_CLK,
  input wire RST_B,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  input wire BAT_PRESENT,
  input wire LOW_LOAD,
  input wire UPD_VALID,
  input wire [4:0] UPD_INDEX,
  input wire [15:0] UPD_WORD,
  output reg SOC_INT,
  output reg [4:0] POWER_MODE,
  output reg LOCKED
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_AACK = 7'h04;
  localparam [6:0] ST_RX = 7'h08;
  localparam [6:0] ST_RACK = 7'h10;
  localparam [6:0] ST_TX = 7'h20;
  localparam [6:0] ST_TACK = 7'h40;
  localparam [4:0] PM_NORMAL = 5'h01;
  localparam [4:0] PM_SLEEP = 5'h02;
  localparam [4:0] PM_SLEEP_PLUS = 5'h04;
  localparam [4:0] PM_HIBERNATE = 5'h08;
  localparam [4:0] PM_BAT_CHECK = 5'h10;
  localparam [15:0] SOC_CYC = SOC_PULSE_CYC[15:0];
  localparam [7:0] SOC_CODE = `GCRM_CODE_STATE_OF_CHARGE;
  localparam [4:0] SOC_INDEX = SOC_CODE[5:1];
  localparam [7:0] GAP_CODE = `GCRM_CODE_GAP;

  function reg_mapped;
    input [7:0] c;
    begin
      reg_mapped = (c < `GCRM_CODE_REG_END) &&
        (c[7:1] != GAP_CODE[7:1]);
    end
  endfunction

  function flash_mapped;
    input [7:0] c;
    begin
      flash_mapped = (c >= `GCRM_CODE_FLASH_BASE) &&
        (c < `GCRM_CODE_FLASH_END);
    end
  endfunction

  wire [3:0] sync_q;
  wire scl_s = sync_q[0];
  wire sda_s = sync_q[1];
  wire bat_s = sync_q[2];
  wire low_s = sync_q[3];
  reg scl_d;
  reg sda_d;
  reg [6:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] ptr_reg;
  reg first_reg;
  reg rw_reg;
  reg wr_en_reg;
  reg [7:0] wr_code_reg;
  reg [7:0] wr_data_reg;
  reg [7:0] ctl_lo_reg;
  reg ctl_status_reg;
  reg key0_seen_reg;
  reg blk_sel_reg;
  reg hib_req_reg;
  reg snooze_reg;
  reg pend_reg;
  reg [4:0] pend_index_reg;
  reg [15:0] pend_word_reg;
  reg [15:0] soc_reg;
  reg [15:0] soc_cnt_reg;
  reg [4:0] pm_next;
  reg [7:0] tx_byte;
  reg [4:0] reg_addr;
  reg [1:0] reg_we;
  reg [15:0] reg_wdata;
  wire [15:0] reg_rdata;
  wire [7:0] flash_rdata;
  wire [15:0] status_word;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  wire [15:0] sub = {wr_data_reg, ctl_lo_reg};
  wire wr_ok = (POWER_MODE == PM_NORMAL) &&
    (~LOCKED || wr_code_reg <= `GCRM_CODE_AT_RATE_HI);
  wire flash_we = wr_en_reg && wr_ok && ~LOCKED &&
    flash_mapped(wr_code_reg);
  wire ctl_hi_wr = wr_en_reg && wr_ok &&
    wr_code_reg == `GCRM_CODE_CONTROL_HI;

  gcrm_sync #(
    .W(4)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d({LOW_LOAD, BAT_PRESENT, SDA_IN, SCL_IN}),
    .q(sync_q)
  );

  gcrm_mem #(
    .AW(5),
    .LN(2)
  ) u_regs (
    .clk(CORE_CLK),
    .addr(reg_addr),
    .we(reg_we),
    .wdata(reg_wdata),
    .rdata(reg_rdata)
  );

  // one memory holds both user blocks; the select bit is the top address
  gcrm_mem #(
    .AW(6),
    .LN(1)
  ) u_flash (
    .clk(CORE_CLK),
    .addr(flash_we ? {blk_sel_reg, wr_code_reg[4:0]} :
      {blk_sel_reg, ptr_reg[4:0]}),
    .we(flash_we),
    .wdata(wr_data_reg),
    .rdata(flash_rdata)
  );

  assign status_word = {2'h0, LOCKED, 5'h0, 1'b1, hib_req_reg, snooze_reg,
    POWER_MODE == PM_SLEEP || POWER_MODE == PM_SLEEP_PLUS, 4'h0};

  // host writes win the port; gauge updates wait in pend_reg until a cycle with no host write
  always @*
  begin
    reg_addr = ptr_reg[5:1];
    reg_we = 2'b00;
    reg_wdata = pend_word_reg;
    if (wr_en_reg && wr_ok && reg_mapped(wr_code_reg))
    begin
      reg_addr = wr_code_reg[5:1];
      reg_we = wr_code_reg[0] ? 2'b10 : 2'b01;
      reg_wdata = {wr_data_reg, wr_data_reg};
    end
    else if (pend_reg)
    begin
      reg_addr = pend_index_reg;
      reg_we = 2'b11;
    end
  end

  always @*
  begin
    tx_byte = 8'h00;
    if (reg_mapped(ptr_reg))
    begin
      if (ptr_reg[7:1] == 7'h00 && ctl_status_reg)
      begin
        tx_byte = ptr_reg[0] ? status_word[15:8] : status_word[7:0];
      end
      else
      begin
        tx_byte = ptr_reg[0] ? reg_rdata[15:8] : reg_rdata[7:0];
      end
    end
    else if (flash_mapped(ptr_reg))
    begin
      tx_byte = flash_rdata;
    end
    else if (ptr_reg == `GCRM_CODE_FLASH_BLOCK_SELECT)
    begin
      tx_byte = {7'h00, blk_sel_reg};
    end
  end

  // serial engine: code byte first, then data bytes with auto increment
  always @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      first_reg <= 1'b1;
      rw_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_code_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      SDA_OE <= 1'b0;
      SDA_OUT <= 1'b0;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      wr_en_reg <= 1'b0;
      SDA_OUT <= 1'b0;
      if (bus_start)
      begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        first_reg <= 1'b1;
        SDA_OE <= 1'b0;
      end
      else if (bus_stop)
      begin
        state_reg <= ST_IDLE;
        SDA_OE <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_ADDR, ST_RX:
          begin
            if (scl_rise)
            begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            else if (scl_fall && bit_cnt_reg == 4'h8)
            begin
              if (state_reg == ST_RX)
              begin
                state_reg <= ST_RACK;
                SDA_OE <= 1'b1;
                first_reg <= 1'b0;
                if (first_reg)
                begin
                  ptr_reg <= shift_reg;
                end
                else
                begin
                  wr_en_reg <= 1'b1;
                  wr_code_reg <= ptr_reg;
                  wr_data_reg <= shift_reg;
                  ptr_reg <= ptr_reg + 8'h01;
                end
              end
              else if (shift_reg[7:1] == DEV_ADDR)
              begin
                state_reg <= ST_AACK;
                SDA_OE <= 1'b1;
                rw_reg <= shift_reg[0];
              end
              else
              begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_AACK, ST_RACK, ST_TACK:
          begin
            if (scl_rise && state_reg == ST_TACK && sda_s)
            begin
              state_reg <= ST_IDLE;
            end
            else if (scl_fall && (state_reg == ST_RACK || !rw_reg))
            begin
              state_reg <= ST_RX;
              bit_cnt_reg <= 4'h0;
              SDA_OE <= 1'b0;
            end
            else if (scl_fall)
            begin
              state_reg <= ST_TX;
              shift_reg <= tx_byte;
              SDA_OE <= ~tx_byte[7];
              bit_cnt_reg <= 4'h1;
              ptr_reg <= ptr_reg + 8'h01;
            end
          end
          ST_TX:
          begin
            if (scl_fall && bit_cnt_reg == 4'h8)
            begin
              state_reg <= ST_TACK;
              SDA_OE <= 1'b0;
            end
            else if (scl_fall)
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              SDA_OE <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          default:
          begin
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // control subcommands, access mode and flash block select
  always @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ctl_lo_reg <= 8'h00;
      ctl_status_reg <= 1'b1;
      key0_seen_reg <= 1'b0;
      LOCKED <= 1'b1;
      blk_sel_reg <= 1'b0;
      hib_req_reg <= 1'b0;
      snooze_reg <= 1'b0;
    end
    else
    begin
      if (wr_en_reg && wr_ok &&
        wr_code_reg == `GCRM_CODE_CONTROL_COMMAND_WORD)
      begin
        ctl_lo_reg <= wr_data_reg;
      end
      if (wr_en_reg && wr_ok && ~LOCKED &&
        wr_code_reg == `GCRM_CODE_FLASH_BLOCK_SELECT)
      begin
        blk_sel_reg <= wr_data_reg[0];
      end
      if (POWER_MODE == PM_HIBERNATE && pm_next == PM_NORMAL)
      begin
        hib_req_reg <= 1'b0;
      end
      if (ctl_hi_wr)
      begin
        ctl_status_reg <= sub == `GCRM_SUB_STATUS;
        key0_seen_reg <= sub == `GCRM_UNLOCK_KEY0;
        if (sub == `GCRM_SUB_LOCK)
        begin
          LOCKED <= 1'b1;
        end
        if (key0_seen_reg && sub == `GCRM_UNLOCK_KEY1)
        begin
          LOCKED <= 1'b0;
        end
        if (sub == `GCRM_SUB_SET_HIBERNATE)
        begin
          hib_req_reg <= 1'b1;
        end
        if (sub == `GCRM_SUB_CLEAR_HIBERNATE)
        begin
          hib_req_reg <= 1'b0;
        end
        if (sub == `GCRM_SUB_SET_SNOOZE)
        begin
          snooze_reg <= 1'b1;
        end
        if (sub == `GCRM_SUB_CLEAR_SNOOZE)
        begin
          snooze_reg <= 1'b0;
        end
      end
    end
  end

  // a bus start only wakes the sleep modes; hibernate waits for load
  always @*
  begin
    pm_next = POWER_MODE;
    case (POWER_MODE)
      PM_NORMAL:
        if (low_s)
          pm_next = snooze_reg ? PM_SLEEP_PLUS : PM_SLEEP;
      PM_SLEEP:
        if (bus_start || !low_s)
          pm_next = PM_NORMAL;
        else if (hib_req_reg)
          pm_next = PM_HIBERNATE;
      PM_SLEEP_PLUS:
        if (bus_start || !low_s)
          pm_next = PM_NORMAL;
      PM_HIBERNATE:
        if (!low_s)
          pm_next = PM_NORMAL;
      PM_BAT_CHECK:
        if (bat_s)
          pm_next = PM_NORMAL;
      default:
        pm_next = PM_BAT_CHECK;
    endcase
    if (!bat_s)
    begin
      pm_next = PM_BAT_CHECK;
    end
  end

  // gauge updates and the state-of-charge interrupt pulse
  always @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      POWER_MODE <= PM_BAT_CHECK;
      pend_reg <= 1'b0;
      pend_index_reg <= 5'h00;
      pend_word_reg <= 16'h0000;
      soc_reg <= 16'h0000;
      soc_cnt_reg <= 16'h0000;
      SOC_INT <= 1'b0;
    end
    else
    begin
      POWER_MODE <= pm_next;
      if (UPD_VALID)
      begin
        pend_reg <= 1'b1;
        pend_index_reg <= UPD_INDEX;
        pend_word_reg <= UPD_WORD;
      end
      else if (reg_we == 2'b11)
      begin
        pend_reg <= 1'b0;
      end
      if (UPD_VALID && UPD_INDEX == SOC_INDEX && UPD_WORD != soc_reg)
      begin
        soc_reg <= UPD_WORD;
        soc_cnt_reg <= SOC_CYC;
        SOC_INT <= 1'b1;
      end
      else if (soc_cnt_reg != 16'h0000)
      begin
        soc_cnt_reg <= soc_cnt_reg - 16'h0001;
        SOC_INT <= soc_cnt_reg != 16'h0001;
      end
    end
  end
endmodule

// ==== testbench/gcrm_host.sv ====
`timescale 1ns/10ps
`include "gcrm_map.vh"
module gcrm_host #(
  parameter [6:0] ADDR = `GCRM_DEV_ADDR
) (
  input wire clk,
  output logic scl = 1'b1,
  output logic sda_pull = 1'b0,
  input wire sda_line
);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // clock low 6 cycles, high 2: 800 ns per bit, low long enough to answer
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= !b;
    tick(5);
    scl <= 1'b1;
    tick(2);
    r = sda_line;
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic put(input logic [7:0] b, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ok = ok && !r;
  endtask
  task automatic get(output logic [7:0] b, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
  task automatic start(input logic rep);
    if (rep)
    begin
      sda_pull <= 1'b0;
      tick(5);
      scl <= 1'b1;
    end
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_pull <= 1'b1;
    tick(5);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(8);
  endtask
  // code first, then data in the same frame
  task automatic write_bytes(input logic [7:0] c, input logic [7:0] d[$],
                             output logic ok);
    ok = 1'b1;
    start(1'b0);
    put({ADDR, 1'b0}, ok);
    put(c, ok);
    foreach (d[i])
      put(d[i], ok);
    stop();
  endtask
  task automatic read_bytes(input logic [7:0] c, input int n,
                            output logic [7:0] d[$], output logic ok);
    logic [7:0] b;
    ok = 1'b1;
    d = {};
    start(1'b0);
    put({ADDR, 1'b0}, ok);
    put(c, ok);
    start(1'b1);
    put({ADDR, 1'b1}, ok);
    for (int i = 0; i < n; i++)
    begin
      get(b, i == n - 1);
      d.push_back(b);
    end
    stop();
  endtask
endmodule

// ==== testbench/gcrm_properties.sv ====
`timescale 1ns/10ps
module gcrm_properties #(
  parameter SOC_PULSE_CYC = 20
) (
  input wire CORE_CLK,
  input wire RST_B,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire BAT_PRESENT,
  input wire LOW_LOAD,
  input wire UPD_VALID,
  input wire [4:0] UPD_INDEX,
  input wire [15:0] UPD_WORD,
  input wire SOC_INT,
  input wire [4:0] POWER_MODE,
  input wire LOCKED
);
  // a soc update that changes the word restarts the pulse; the run length restarts on any soc update
  reg [15:0] run_reg;
  always @(posedge CORE_CLK or negedge RST_B)
    if (!RST_B)
      run_reg <= 16'h0000;
    else if (!SOC_INT || (UPD_VALID && UPD_INDEX == 5'd22))
      run_reg <= 16'h0000;
    else
      run_reg <= run_reg + 16'h0001;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sda_open_a: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  oe_on_low_a: assert property ($rose(SDA_OE) |-> !SCL_IN)
    else $error("data pull starts with clock high");
  stop_free_a: assert property (SCL_IN && $rose(SDA_IN) |->
    ##[1:6] !SDA_OE) else $error("data pin held after stop");
  rst_lock_a: assert property ($rose(RST_B) |->
    LOCKED && POWER_MODE == 5'h10) else $error("reset state wrong");
  mode_hot_a: assert property ($onehot(POWER_MODE))
    else $error("power mode not one-hot");
  no_bat_a: assert property (!BAT_PRESENT [*3] |->
    ##[0:1] POWER_MODE == 5'h10) else $error("no battery check mode");
  bat_in_a: assert property ((POWER_MODE == 5'h10
    && BAT_PRESENT) [*3] |-> ##[0:1] POWER_MODE != 5'h10)
    else $error("stuck in check");
  sleep_go_a: assert property ((POWER_MODE == 5'h01 && LOW_LOAD
    && BAT_PRESENT) [*3] |-> ##[0:1] POWER_MODE != 5'h01)
    else $error("no sleep on low load");
  wake_up_a: assert property ((POWER_MODE[3:1] != 3'b000
    && !LOW_LOAD && BAT_PRESENT) [*3] |-> ##[0:1] POWER_MODE == 5'h01)
    else $error("no wake on load");
  soc_len_a: assert property (run_reg <= SOC_PULSE_CYC + 2)
    else $error("soc pulse too long");
  soc_cause_a: assert property ($rose(SOC_INT) |->
    $past(UPD_VALID) || $past(UPD_VALID, 2)) else $error("stray soc pulse");
endmodule

bind gcrm_top gcrm_properties #(.SOC_PULSE_CYC(SOC_PULSE_CYC)) u_props (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .BAT_PRESENT(BAT_PRESENT),
  .LOW_LOAD(LOW_LOAD), .UPD_VALID(UPD_VALID), .UPD_INDEX(UPD_INDEX),
  .UPD_WORD(UPD_WORD), .SOC_INT(SOC_INT), .POWER_MODE(POWER_MODE),
  .LOCKED(LOCKED));

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
`include "gcrm_map.vh"
`define CHK(w, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("[ERR] %s exp %0h got %0h", w, e, g); \
    end \
  end
module testbench;
  localparam SOC_CYC = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic bat = 1'b0;
  logic low = 1'b0;
  logic uv = 1'b0;
  logic [4:0] ui = 5'h00;
  logic [15:0] uw = 16'h0000;
  wire scl, pull, sda_out, sda_oe, soc_int, locked;
  wire [4:0] mode;
  wire sda = !((sda_oe && !sda_out) || pull);
  int num_errors = 0;
  int checked = 0;
  int n;
  logic [31:0] seed = 32'h00012EB2;
  logic [15:0] v, w;
  logic [7:0] q[$];
  logic [7:0] fl[0:63];
  logic ok;

  always #50 clk = ~clk;

  gcrm_top #(.SOC_PULSE_CYC(SOC_CYC)) u_gcrm_top (.CORE_CLK(clk),
    .RST_B(rst_b), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .BAT_PRESENT(bat), .LOW_LOAD(low), .UPD_VALID(uv),
    .UPD_INDEX(ui), .UPD_WORD(uw), .SOC_INT(soc_int), .POWER_MODE(mode),
    .LOCKED(locked));
  gcrm_host u_gcrm_host (.clk(clk), .scl(scl), .sda_pull(pull),
    .sda_line(sda));

  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [15:0] stat(input logic lk, hb, sz, sl);
    return {2'b00, lk, 5'h00, 1'b1, hb, sz, sl, 4'h0};
  endfunction

  task automatic wr16(input logic [7:0] c, input logic [15:0] x);
    u_gcrm_host.write_bytes(c, {x[7:0], x[15:8]}, ok);
    `CHK("ack", 1'b1, ok)
  endtask
  task automatic rd16(input logic [7:0] c, output logic [15:0] x);
    u_gcrm_host.read_bytes(c, 2, q, ok);
    x = {q[1], q[0]};
    `CHK("ack", 1'b1, ok)
  endtask
  task automatic upd(input logic [4:0] i, input logic [15:0] x);
    ui <= i;
    uw <= x;
    uv <= 1'b1;
    @(posedge clk);
    uv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_mode(input logic [4:0] m);
    n = 0;
    while (mode !== m && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("mode", m, mode)
    @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    $display("[ERR] watchdog exp done got hang");
    tally_and_finish();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK("locked", 1'b1, locked)
    `CHK("mode", 5'h10, mode)
    @(posedge clk);
    bat <= 1'b1;
    wait_mode(5'h01);
    rd16(8'h00, w);
    `CHK("status", stat(1, 0, 0, 0), w)
    v = rnd();
    wr16(8'h02, v);
    rd16(8'h02, w);
    `CHK("at rate", v, w)
    for (int c = 4; c <= 8'h30; c += 2)
      if (c != 8'h2A)
      begin
        v = rnd();
        upd(c[5:1], v);
        rd16(c[7:0], w);
        `CHK("word", v, w)
        wr16(c[7:0], ~v);
        rd16(c[7:0], w);
        `CHK("locked word", v, w)
      end
    rd16(8'h2A, w);
    `CHK("unmapped", 16'h0000, w)
    wr16(8'h00, `GCRM_UNLOCK_KEY0);
    wr16(8'h00, `GCRM_UNLOCK_KEY1);
    @(negedge clk);
    `CHK("unlocked", 1'b0, locked)
    v = rnd();
    wr16(8'h08, v);
    rd16(8'h08, w);
    `CHK("open word", v, w)
    for (int b = 0; b < 2; b++)
    begin
      q = {};
      for (int i = 0; i < 32; i++)
      begin
        fl[b * 32 + i] = 8'(rnd());
        q.push_back(fl[b * 32 + i]);
      end
      u_gcrm_host.write_bytes(8'h3F, {8'(b)}, ok);
      u_gcrm_host.write_bytes(8'h40, q, ok);
    end
    for (int b = 0; b < 2; b++)
    begin
      u_gcrm_host.write_bytes(8'h3F, {8'(b)}, ok);
      u_gcrm_host.read_bytes(8'h40, 32, q, ok);
      for (int i = 0; i < 32; i++)
        `CHK("flash", fl[b * 32 + i], q[i])
    end
    wr16(8'h00, `GCRM_SUB_SET_SNOOZE);
    wr16(8'h00, `GCRM_SUB_STATUS);
    rd16(8'h00, w);
    `CHK("snooze", stat(0, 0, 1, 0), w)
    low <= 1'b1;
    wait_mode(5'h04);
    low <= 1'b0;
    wait_mode(5'h01);
    wr16(8'h00, `GCRM_SUB_CLEAR_SNOOZE);
    wr16(8'h00, `GCRM_SUB_SET_HIBERNATE);
    low <= 1'b1;
    wait_mode(5'h08);
    rd16(8'h02, v);
    wr16(8'h02, ~v);
    rd16(8'h02, w);
    `CHK("asleep write", v, w)
    low <= 1'b0;
    wait_mode(5'h01);
    wr16(8'h00, `GCRM_SUB_STATUS);
    rd16(8'h00, w);
    `CHK("wake status", stat(0, 0, 0, 0), w)
    wr16(8'h00, `GCRM_SUB_LOCK);
    @(negedge clk);
    `CHK("relocked", 1'b1, locked)
    @(posedge clk);
    v = rnd();
    upd(5'd22, v);
    upd(5'd22, ~v);
    n = 0;
    while (soc_int === 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    `CHK("soc pulse", SOC_CYC - 2, n)
    @(posedge clk);
    upd(5'd22, ~v);
    @(negedge clk);
    `CHK("soc same", 1'b0, soc_int)
    @(posedge clk);
    bat <= 1'b0;
    wait_mode(5'h10);
    tally_and_finish();
  end
endmodule
